// ===== src/fwl_consts.vh
// constants for the flash write lock-and-key guard
// assumes inclusion by bare name from the design files
`ifndef FWL_CONSTS_VH
`define FWL_CONSTS_VH

`define FWL_KEY_ADDR     8'hB7
`define FWL_KEY_RESET    8'h00
`define FWL_KEY_FIRST    8'hA5
`define FWL_KEY_SECOND   8'hF1
`define FWL_ST_LOCKED    2'h0
`define FWL_ST_HALF      2'h1
`define FWL_ST_OPEN      2'h2
`define FWL_ST_DEAD      2'h3
`define FWL_ST_LSB       0
`define FWL_ST_MSB       1

`endif

// ===== src/fwl_sfr_port.v
// special-function register access port for the lock-and-key register
// assumes a single-cycle processor sfr bus on sys_clk
`timescale 1ns/1ps
`include "fwl_consts.vh"

module fwl_sfr_port #(
	parameter ADDR_W = 8
) (
	input  wire              sys_clk,
	input  wire              rst_n,
	input  wire [ADDR_W-1:0] sfr_addr,
	input  wire              sfr_wr,
	input  wire              sfr_rd,
	input  wire [7:0]        sfr_wdata,
	input  wire [1:0]        lock_state,
	output wire              key_wr,
	output wire [7:0]        key_data,
	output reg  [7:0]        sfr_rdata
);

	wire hit;

	assign hit      = (sfr_addr == `FWL_KEY_ADDR);
	assign key_wr   = hit & sfr_wr;
	assign key_data = sfr_wdata;

	// read data from a flop; other addresses return zero
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sfr_rdata <= `FWL_KEY_RESET;
		end else if (hit & sfr_rd) begin
			sfr_rdata <= {6'h00, lock_state};
		end else begin
			sfr_rdata <= 8'h00;
		end
	end

endmodule // fwl_sfr_port

// ===== src/fwl_lock.v
// flash write lock-and-key guard: key sequencing, one-shot unlock, permanent lock
// assumes flash controller pulses on sys_clk and an sfr bus from the processor
`timescale 1ns/1ps
`include "fwl_consts.vh"

// Overview of operation
// - only the ordered key pair first then second unlocks flash write or erase
// - locked state reads 00 and is the reset state
// - correct first key moves to state 01 awaiting second key
// - correct second key gives state 10 and allows one write or erase
// - completion of the write or erase relocks without software action
// - any wrong or misordered key write locks permanently until reset
// - write or erase attempted while not enabled is refused and locks permanently
// - permanent lock reads 11 and refuses everything until reset
// - key register read returns lock state in bits one and zero
module fwl_lock (
	input  wire       sys_clk,
	input  wire       rst_n,
	input  wire [7:0] sfr_addr,
	input  wire       sfr_wr,
	input  wire       sfr_rd,
	input  wire [7:0] sfr_wdata,
	output wire [7:0] sfr_rdata,
	input  wire       flash_op_req,
	input  wire       flash_op_done,
	output wire       flash_op_grant,
	output wire       flash_op_refuse,
	output wire [1:0] lock_state
);

	// ****************************************
	// one-hot states
	// ****************************************
	localparam S_LOCKED = 4'b0001;
	localparam S_HALF   = 4'b0010;
	localparam S_OPEN   = 4'b0100;
	localparam S_DEAD   = 4'b1000;

	reg  [3:0] state_reg;
	reg  [3:0] state_next;
	reg        busy_reg;
	reg        busy_next;
	reg  [1:0] code_reg;
	wire       key_wr;
	wire [7:0] key_data;

	fwl_sfr_port #(
		.ADDR_W (8)
	) u_port (
		.sys_clk    (sys_clk),
		.rst_n      (rst_n),
		.sfr_addr   (sfr_addr),
		.sfr_wr     (sfr_wr),
		.sfr_rd     (sfr_rd),
		.sfr_wdata  (sfr_wdata),
		.lock_state (code_reg),
		.key_wr     (key_wr),
		.key_data   (key_data),
		.sfr_rdata  (sfr_rdata)
	);

	// ****************************************
	// key sequencing and operation gate
	// ****************************************
	function [1:0] enc;
		input [3:0] s;
		begin
			case (s)
				S_HALF:  enc = `FWL_ST_HALF;
				S_OPEN:  enc = `FWL_ST_OPEN;
				S_DEAD:  enc = `FWL_ST_DEAD;
				default: enc = `FWL_ST_LOCKED;
			endcase
		end
	endfunction

	// grant only when open and no operation already in flight, so one op per unlock
	assign flash_op_grant  = flash_op_req & (state_reg == S_OPEN) & ~busy_reg;
	assign flash_op_refuse = flash_op_req & ~flash_op_grant;
	assign lock_state      = code_reg;

	always @* begin
		state_next = state_reg;
		busy_next  = busy_reg;
		case (state_reg)
			S_LOCKED: begin
				if (flash_op_req) begin
					state_next = S_DEAD;
				end else if (key_wr) begin
					if (key_data == `FWL_KEY_FIRST) begin
						state_next = S_HALF;
					end else begin
						state_next = S_DEAD;
					end
				end
			end
			S_HALF: begin
				if (flash_op_req) begin
					state_next = S_DEAD;
				end else if (key_wr) begin
					if (key_data == `FWL_KEY_SECOND) begin
						state_next = S_OPEN;
					end else begin
						state_next = S_DEAD;
					end
				end
			end
			S_OPEN: begin
				// a key write during an unlock is out of sequence
				if (key_wr) begin
					state_next = S_DEAD;
					busy_next  = 1'b0;
				end else if (flash_op_done & (busy_reg | flash_op_grant)) begin
					state_next = S_LOCKED;
					busy_next  = 1'b0;
				end else if (flash_op_grant) begin
					busy_next = 1'b1;
				end else if (flash_op_req & busy_reg) begin
					state_next = S_DEAD;
					busy_next  = 1'b0;
				end
			end
			S_DEAD: begin
				state_next = S_DEAD;
				busy_next  = 1'b0;
			end
			default: begin
				state_next = S_DEAD;
				busy_next  = 1'b0;
			end
		endcase
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= S_LOCKED;
			busy_reg  <= 1'b0;
			code_reg  <= `FWL_ST_LOCKED;
		end else begin
			state_reg <= state_next;
			busy_reg  <= busy_next;
			code_reg  <= enc(state_next);
		end
	end

endmodule // fwl_lock

// ===== verif/fwl_lock_sva.sv
// checker for the flash lock guard: key order, grant, relock, readback
// assumes a single sys_clk domain and fwl_lock as the bind target
`timescale 1ns/1ps
module fwl_lock_sva (
	input wire       sys_clk,
	input wire       rst_n,
	input wire [7:0] sfr_addr,
	input wire       sfr_wr,
	input wire       sfr_rd,
	input wire [7:0] sfr_wdata,
	input wire [7:0] sfr_rdata,
	input wire       flash_op_req,
	input wire       flash_op_done,
	input wire       flash_op_grant,
	input wire       flash_op_refuse,
	input wire [1:0] lock_state
);
	// ****
	// checks
	// ****
	wire kw = sfr_wr && sfr_addr == 8'hB7;
	wire ok = (lock_state == 2'h0 && sfr_wdata == 8'hA5) || (lock_state == 2'h1 && sfr_wdata == 8'hF1);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence s_half; lock_state == 2'h1 && kw && sfr_wdata == 8'hF1 && !flash_op_req; endsequence
	sequence s_grant; flash_op_grant && !kw; endsequence
	reset_locked_a: assert property ($rose(rst_n) |-> lock_state == 2'h0) else $error("not locked");
	first_key_a: assert property (lock_state == 2'h0 && kw && sfr_wdata == 8'hA5 && !flash_op_req |=> lock_state == 2'h1)
		else $error("first key lost");
	second_key_a: assert property (s_half |=> lock_state == 2'h2) else $error("no unlock");
	bad_key_a: assert property (kw && !ok |=> lock_state == 2'h3) else $error("bad key kept");
	refuse_op_a: assert property (flash_op_req && lock_state != 2'h2 |-> flash_op_refuse && !flash_op_grant ##1 lock_state == 2'h3)
		else $error("op not refused");
	dead_hold_a: assert property (lock_state == 2'h3 |=> lock_state == 2'h3) else $error("dead left");
	relock_done_a: assert property (s_grant ##1 (flash_op_done && !flash_op_req && !kw) |=> lock_state == 2'h0)
		else $error("no relock");
	read_state_a: assert property (sfr_rd && sfr_addr == 8'hB7 |=> sfr_rdata == {6'h00, $past(lock_state)})
		else $error("bad readback");
endmodule // fwl_lock_sva
bind fwl_lock fwl_lock_sva i_sva (.*);

// ===== verif/fwl_lock_tb.sv
// random key and flash request traffic checked against an integer model
// assumes fwl_lock on a 25 MHz sys_clk with async active-low reset
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; $display("mismatch %0t value", $time); end end
module fwl_lock_tb;
	reg        sys_clk = 0, rst_n = 0, sfr_wr = 0, sfr_rd = 0, flash_op_req = 0, flash_op_done = 0;
	reg  [7:0] sfr_addr = 8'hB7, sfr_wdata = 8'h00;
	reg [31:0] rnd = 32'h056B;
	wire [7:0] sfr_rdata;
	wire       flash_op_grant, flash_op_refuse;
	wire [1:0] lock_state;
	integer    m = 0, n, n_errors = 0, compares = 0;
	fwl_lock i_fwl_lock (.sys_clk(sys_clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .flash_op_req(flash_op_req), .flash_op_done(flash_op_done),
		.flash_op_grant(flash_op_grant), .flash_op_refuse(flash_op_refuse), .lock_state(lock_state));
	// ****
	// drivers, all launched and ended on a falling edge
	// ****
	initial forever #20 sys_clk = ~sys_clk;
	function [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task end_of_test;
		$display("compares %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task key(input [7:0] v);
		sfr_wdata = v;
		sfr_wr = 1;
		@(negedge sys_clk);
		sfr_wr = 0;
		// writes to other addresses must leave the lock untouched
		if (sfr_addr == 8'hB7) m = (m == 0 && v == 8'hA5) ? 1 : (m == 1 && v == 8'hF1) ? 2 : 3;
	endtask
	task op;
		flash_op_req = 1;
		#1 `CHK(flash_op_grant, m == 2)
		`CHK(flash_op_refuse, m != 2)
		@(negedge sys_clk);
		// a request held into a second cycle is a second op on one unlock
		if (m == 2 && rnd[9]) begin
			#1 `CHK(flash_op_grant, 1'b0)
			`CHK(flash_op_refuse, 1'b1)
			@(negedge sys_clk);
			m = 3;
		end
		flash_op_req = 0;
		flash_op_done = (m == 2);
		m = (m == 2) ? 0 : 3;
		@(negedge sys_clk);
		flash_op_done = 0;
	endtask
	task rd;
		sfr_rd = 1;
		@(negedge sys_clk);
		sfr_rd = 0;
		`CHK(sfr_rdata, (sfr_addr == 8'hB7) ? {6'h00, m[1:0]} : 8'h00)
		`CHK(lock_state, m[1:0])
	endtask
	// correct keys are favoured so that the unlocked state is reached often
	initial begin
		repeat (16) @(negedge sys_clk);
		rst_n = 1;
		for (n = 0; n < 600; n++) begin
			rnd = lfsr(rnd);
			sfr_addr = rnd[6] ? rnd[23:16] : 8'hB7;
			if (rnd[5:3] == 0) begin
				rst_n = 0;
				@(negedge sys_clk);
				rst_n = 1;
				m = 0;
			end
			if (!rnd[2]) key(m == 1 ? 8'hF1 : 8'hA5);
			else if (rnd[1]) op;
			else key(rnd[15:8]);
			rd;
		end
		$display("test random done");
		end_of_test;
	end
	// about seventeen times the expected run length
	initial begin
		#1000000;
		n_errors++;
		end_of_test;
	end
endmodule // fwl_lock_tb
